// ===== hdl/dac_serial_host.sv
// Behaviour
// - word is 24 bits: two mode, six address, sixteen data bits
// - sync falls, then at least 24 falling clock edges before sync rises
// - host raises sync before a 25th falling edge without checksum
// - gated clock of exactly 24 pulses may raise sync any time after
// - serial clock at most 50 MHz writes, 20 MHz reads
// - readback: write mode 00 select word, data comes next transfer
// - after single channel write, next write completes 600 ns later
// - multi-channel write needs 600 ns per channel before next completes
// - narrow variant low two bits reserved, written as zero
// - checksum mode appends crc-8 poly 0x07, 32 bits per frame
`timescale 1ns/100ps
`default_nettype none
module dac_serial_host
    import dac_host_pkg::*;
(
    input  wire logic        clk,          // 50 MHz system clock
    input  wire logic        rst_n,        // async reset, low
    input  wire logic [3:0]  addr,         // software register offset
    input  wire logic [31:0] wdata,        // software write data
    input  wire logic        wr,           // write strobe
    input  wire logic        rd,           // read strobe
    output logic      [31:0] rdata,        // read data, cycle after rd
    output logic             sclk,         // serial clock to device
    output logic             sync_n,       // frame sync, low in frame
    output logic             sdi,          // serial data to device
    input  wire logic        sdo,          // serial data from device
    input  wire logic        crc_error_n,  // device checksum error, low
    output logic             busy          // frame or pacing in progress
);
    typedef struct packed {
        link_state_t         st;
        link_out_t           pins;
        logic [3:0]          div;
        logic [5:0]          nbits;
        logic [5:0]          total;
        logic [31:0]         shreg;
        logic [23:0]         rx;
        logic [23:0]         word;
        logic                crc_en;
        logic                rd_next;
        logic                rd_pend;
        logic                rd_valid;
        logic [23:0]         rd_data;
        logic [PACE_W-1:0]   pace;
        logic [31:0]         rdata;
        logic                busy;
    } state_t;

    state_t     s;
    state_t     next_s;
    logic [7:0] crc;
    logic       sdo_s;
    logic       err_n_s;
    logic [23:0] tx_word;

    dac_crc8 u_crc (
        .word (tx_word),
        .crc  (crc)
    );

    dac_sync2 u_sdo (
        .clk   (clk),
        .rst_n (rst_n),
        .d     (sdo),
        .q     (sdo_s)
    );

    // error pin idles high, so its flops start high: a low start would
    // read as a checksum error for two cycles after every reset
    dac_sync2 #(
        .INIT (1'b1)
    ) u_err (
        .clk   (clk),
        .rst_n (rst_n),
        .d     (crc_error_n),
        .q     (err_n_s)
    );

    // a capture frame sends a no-op in place of the word register
    assign tx_word = s.rd_pend ? NOP_WORD : s.word;

    // settle time owed to the calculation engine after a write
    function automatic logic [PACE_W-1:0] pace_for(input logic [23:0] w);
        logic [PACE_W-1:0] n;
        n = PACE_W'(STAGE1_CYC);
        if (w[23:22] != MODE_SPECIAL && w[20:19] == ADDR_PAIR_ALL) begin
            if (w[18:16] == ADDR_ALL) begin
                n = PACE_W'(STAGE1_CYC * CH_ALL);
            end else if (w[18:16] == ADDR_GRP0 || w[18:16] == ADDR_GRP1) begin
                n = PACE_W'(STAGE1_CYC * CH_GROUP);
            end
        end
        return n;
    endfunction : pace_for

    // frame sequencer
    always_comb begin
        next_s = s;
        case (s.st)
            ST_IDLE: begin
                if (wr && addr == REG_CTRL && wdata[CTRL_GO_BIT]) begin
                    next_s.crc_en  = wdata[CTRL_CRC_BIT];
                    next_s.rd_next = wdata[CTRL_RD_BIT];
                    next_s.busy    = 1'b1;
                    next_s.st      = ST_SYNC;
                end
            end
            ST_SYNC: begin
                // reserved low bits forced to zero when unused by the word
                next_s.shreg = s.crc_en ? {tx_word, crc} : {tx_word, 8'h00};
                next_s.total = s.crc_en ? BITCNT_CRC : BITCNT_WORD;
                next_s.nbits      = '0;
                next_s.div        = '0;
                next_s.pins.sync_n = 1'b0;
                next_s.pins.sclk   = 1'b1;
                next_s.pins.sdi    = next_s.shreg[FRAME_MAX-1];
                next_s.st          = ST_HIGH;
            end
            ST_HIGH: begin
                // falling edge lands in the middle of stable data
                next_s.div = s.div + 4'h1;
                if (s.div == HALF_DIV - 4'h1) begin
                    next_s.div       = '0;
                    next_s.pins.sclk = 1'b0;
                    next_s.nbits     = s.nbits + 6'h01;
                    next_s.st        = ST_LOW;
                end
            end
            ST_LOW: begin
                next_s.div = s.div + 4'h1;
                if (s.div == 4'h1) begin
                    // device output is launched on sclk rise, sample it late
                    next_s.rx = {s.rx[22:0], sdo_s};
                end
                if (s.div == HALF_DIV - 4'h1) begin
                    next_s.div   = '0;
                    next_s.shreg = {s.shreg[FRAME_MAX-2:0], 1'b0};
                    if (s.nbits == s.total) begin
                        next_s.st = ST_END;
                    end else begin
                        next_s.pins.sclk = 1'b1;
                        next_s.pins.sdi  = s.shreg[FRAME_MAX-2];
                        next_s.st        = ST_HIGH;
                    end
                end
            end
            ST_END: begin
                // clock rises again as sync rises; no further falling edge
                next_s.pins.sync_n = 1'b1;
                next_s.pins.sclk   = 1'b1;
                if (s.rd_pend) begin
                    next_s.rd_data  = s.rx;
                    next_s.rd_valid = 1'b1;
                end
                next_s.rd_pend = s.rd_next;
                next_s.pace    = pace_for(tx_word);
                next_s.st      = ST_PACE;
            end
            ST_PACE: begin
                next_s.pace = s.pace - PACE_W'(1);
                if (s.pace == PACE_W'(1)) begin
                    next_s.busy = 1'b0;
                    next_s.st   = ST_IDLE;
                end
            end
            default: begin
                next_s.st = ST_IDLE;
            end
        endcase
        // word register writable only while idle
        if (wr && addr == REG_WORD && s.st == ST_IDLE) begin
            next_s.word = wdata[23:0];
            if (NARROW_DATA) begin
                next_s.word = wdata[23:0] & RSVD_MASK;
            end
        end
        // register read port
        next_s.rdata = '0;
        if (rd) begin
            case (addr)
                REG_WORD:   next_s.rdata = {8'h00, s.word};
                REG_STATUS: next_s.rdata = {28'h0, s.rd_pend, s.rd_valid, ~err_n_s, s.busy};
                REG_RDATA:  next_s.rdata = {8'h00, s.rd_data};
                default:    next_s.rdata = '0;
            endcase
            if (addr == REG_RDATA && !(s.st == ST_END && s.rd_pend)) begin
                next_s.rd_valid = 1'b0;   // set in same cycle wins
            end
        end
    end

    // state register
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            s             <= '0;
            s.st          <= ST_IDLE;
            s.pins.sync_n <= 1'b1;
            s.pins.sclk   <= 1'b1;
        end else begin
            s <= next_s;
        end
    end

    assign sclk   = s.pins.sclk;
    assign sync_n = s.pins.sync_n;
    assign sdi    = s.pins.sdi;
    assign rdata  = s.rdata;
    assign busy   = s.busy;

    // no more falling edges in a frame than its length
    a_edge_count: assert property (@(posedge clk) disable iff (!rst_n)
        s.nbits <= s.total || s.st == ST_IDLE || s.st == ST_SYNC)
        else $error("too many serial clock edges");

    // a frame without checksum ends on exactly one word of edges
    a_word_edges: assert property (@(posedge clk) disable iff (!rst_n)
        ($rose(sync_n) && !s.crc_en) |-> s.nbits == BITCNT_WORD)
        else $error("plain frame edge count wrong");

    // sync only rises after a full word
    a_sync_full: assert property (@(posedge clk) disable iff (!rst_n)
        $rose(sync_n) |-> s.nbits == s.total && s.nbits >= BITCNT_WORD)
        else $error("sync rose before full frame");

    // clock is high while sync moves
    a_sync_clk: assert property (@(posedge clk) disable iff (!rst_n)
        $changed(sync_n) |-> sclk)
        else $error("sync moved with clock low");

    // gated clock: sync rises with the clock, no pulse after the last one
    a_sync_gate: assert property (@(posedge clk) disable iff (!rst_n)
        $rose(sync_n) |-> $rose(sclk))
        else $error("sync rose apart from the clock");

    // data only changes while clock is high
    a_sdi_stable: assert property (@(posedge clk) disable iff (!rst_n)
        (!sync_n && $changed(sdi)) |-> sclk)
        else $error("data changed with clock low");

    // low phase lasts the divider length
    a_low_width: assert property (@(posedge clk) disable iff (!rst_n)
        $fell(sclk) |-> !sclk [*5])
        else $error("serial clock low phase too short");

    // high phase inside a frame lasts the divider length too
    a_high_width: assert property (@(posedge clk) disable iff (!rst_n)
        ($rose(sclk) && !sync_n) |-> sclk [*5])
        else $error("serial clock high phase too short");

    // cycles that sync has stood high, saturating; starts full so the
    // first frame after a reset is not held to a gap it never owed
    logic [PACE_W-1:0] high_run;
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            high_run <= '1;
        end else if (!s.pins.sync_n) begin
            high_run <= '0;
        end else if (high_run != '1) begin
            high_run <= high_run + PACE_W'(1);
        end
    end

    // pacing holds off the next frame at least one stage
    a_pace_gap: assert property (@(posedge clk) disable iff (!rst_n)
        $fell(sync_n) |-> high_run >= PACE_W'(STAGE1_CYC))
        else $error("next frame started before settle time");

    // busy covers the whole frame, so software cannot start another in it
    a_busy_frame: assert property (@(posedge clk) disable iff (!rst_n)
        !sync_n |-> busy)
        else $error("frame running while not busy");

    // multi-channel all-address write waits eight stages
    a_pace_all: assert property (@(posedge clk) disable iff (!rst_n)
        (s.st == ST_END && tx_word[23:22] != MODE_SPECIAL && tx_word[20:16] == 5'h00)
        |=> s.pace == PACE_W'(240))
        else $error("broadcast pacing wrong");

    // checksum frames are 32 bits long
    a_crc_len: assert property (@(posedge clk) disable iff (!rst_n)
        (s.st == ST_SYNC && s.crc_en) |=> s.total == BITCNT_CRC)
        else $error("crc frame length wrong");

    // a capture frame carries a no-op so the readback changes nothing
    a_nop_capture: assert property (@(posedge clk) disable iff (!rst_n)
        (s.st == ST_SYNC && s.rd_pend) |=> s.shreg[FRAME_MAX-1:CRC_BITS] == NOP_WORD)
        else $error("capture frame word not a no-op");
endmodule : dac_serial_host
`default_nettype wire

// ===== hdl/dac_host_pkg.sv
package dac_host_pkg;
    // frame geometry
    localparam int        WORD_BITS     = 24;
    localparam int        CRC_BITS      = 8;
    localparam int        FRAME_MAX     = 32;
    localparam logic [5:0] BITCNT_WORD  = 6'h18;
    localparam logic [5:0] BITCNT_CRC   = 6'h20;
    localparam logic [7:0] CRC_POLY     = 8'h07;   // x^8+x^2+x+1
    localparam logic [7:0] CRC_INIT     = 8'h00;
    // mode bits
    localparam logic [1:0] MODE_SPECIAL = 2'h0;
    localparam logic [1:0] MODE_GAIN    = 2'h1;
    localparam logic [1:0] MODE_OFFSET  = 2'h2;
    localparam logic [1:0] MODE_DATA    = 2'h3;
    // special function codes
    localparam logic [5:0] SF_NOP       = 6'h00;
    localparam logic [5:0] SF_CONTROL   = 6'h01;
    localparam logic [5:0] SF_READBACK  = 6'h05;
    localparam logic [23:0] NOP_WORD    = 24'h000000;
    // narrow data variant: two low frame bits reserved, always sent as zero
    localparam logic       NARROW_DATA  = 1'b0;
    localparam logic [23:0] RSVD_MASK   = 24'hFF_FFFC;
    // address decode
    localparam logic [1:0] ADDR_PAIR_ALL = 2'h0;
    localparam logic [2:0] ADDR_ALL     = 3'h0;
    localparam logic [2:0] ADDR_GRP0    = 3'h1;
    localparam logic [2:0] ADDR_GRP1    = 3'h2;
    // timing at 50 MHz system clock
    localparam int        CLK_PERIOD_NS = 20;
    localparam int        STAGE1_NS     = 600;
    localparam int        STAGE1_CYC    = (STAGE1_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int        CH_ALL        = 8;
    localparam int        CH_GROUP      = 4;
    // serial clock half period in system clocks (5 MHz link, under the 20 MHz read cap)
    localparam logic [3:0] HALF_DIV     = 4'h5;
    localparam int        PACE_W        = 10;
    // software register offsets
    localparam logic [3:0] REG_CTRL     = 4'h0;
    localparam logic [3:0] REG_WORD     = 4'h1;
    localparam logic [3:0] REG_STATUS   = 4'h2;
    localparam logic [3:0] REG_RDATA    = 4'h3;
    localparam int        CTRL_CRC_BIT  = 0;
    localparam int        CTRL_GO_BIT   = 1;
    localparam int        CTRL_RD_BIT   = 2;

    typedef enum logic [2:0] {
        ST_IDLE  = 3'h0,
        ST_SYNC  = 3'h1,
        ST_LOW   = 3'h2,
        ST_HIGH  = 3'h3,
        ST_END   = 3'h4,
        ST_PACE  = 3'h5
    } link_state_t;

    typedef struct packed {
        logic sclk;
        logic sync_n;
        logic sdi;
    } link_out_t;
endpackage : dac_host_pkg

// ===== hdl/dac_crc8.sv
`timescale 1ns/100ps
`default_nettype none
module dac_crc8
    import dac_host_pkg::*;
(
    input  wire logic [23:0] word,   // frame word to protect
    output logic      [7:0]  crc     // checksum to append
);
    // bitwise crc over the word, msb first
    always_comb begin
        logic [7:0] c;
        c = CRC_INIT;
        for (int i = WORD_BITS - 1; i >= 0; i--) begin
            c = (c[7] ^ word[i]) ? ({c[6:0], 1'b0} ^ CRC_POLY) : {c[6:0], 1'b0};
        end
        crc = c;
    end
endmodule : dac_crc8
`default_nettype wire

// ===== hdl/dac_sync2.sv
`timescale 1ns/100ps
`default_nettype none
module dac_sync2 #(
    parameter logic INIT = 1'b0   // level held while in reset
) (
    input  wire logic clk,     // system clock
    input  wire logic rst_n,   // async reset, low
    input  wire logic d,       // pin level
    output logic      q        // synchronised level
);
    logic [1:0] s;
    // two flops, first read only by second
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            s <= {2{INIT}};
        end else begin
            s <= {s[0], d};
        end
    end
    assign q = s[1];
endmodule : dac_sync2
`default_nettype wire

// ===== dv/dac_device_model.sv
`timescale 1ns/100ps
`default_nettype none
module dac_device_model
    import dac_host_pkg::*;
#(
    parameter logic [15:0] CTRL_SEL = 16'h0080    // readback operand for control register
)(
    input  wire logic        clk,          // bench clock, only for idle filler
    input  wire logic        sclk,         // serial clock from host
    input  wire logic        sync_n,       // frame sync from host
    input  wire logic        sdi,          // serial data from host
    input  wire logic        corrupt,      // bench asks to flip first bit
    output logic             sdo,          // readback data
    output logic             crc_error_n,  // checksum error, low
    output logic      [31:0] rx_word,      // last frame as received
    output logic      [5:0]  rx_bits,      // falling edges in last frame
    output logic      [7:0]  commits,      // register updates done
    output logic             bank_used     // bank of last data write
);
    logic [31:0] shreg;
    logic [23:0] rb_shift;
    logic [23:0] word;
    logic [5:0]  cnt;
    logic        rd_pend, err, bank, fill;

    function automatic logic [7:0] crc_of(input logic [23:0] w);
        logic [7:0] c;
        c = 8'h00;
        for (int i = 23; i >= 0; i--) c = {c[6:0], 1'b0} ^ ((c[7] ^ w[i]) ? 8'h07 : 8'h00);
        return c;
    endfunction : crc_of

    initial begin
        {cnt, rd_pend, err, bank, fill, rx_bits, rx_word, commits, bank_used} = '0;
        {shreg, rb_shift, word} = '0;
    end
    // front end wakes on sync fall only
    always @(negedge sync_n) cnt = 6'h00;
    always @(negedge sclk) if (!sync_n) begin
        shreg = {shreg[30:0], sdi ^ (corrupt && cnt == 6'h00)};
        cnt = cnt + 6'h01;
    end
    // next readback bit after each rise, held through the high and low phase
    always @(posedge sclk) if (!sync_n && rd_pend) rb_shift = rb_shift << 1;
    // commit on sync rise; short or odd frames are dropped
    always @(posedge sync_n) begin
        rx_word = shreg;
        rx_bits = cnt;
        rd_pend = 1'b0;
        word = (cnt == 6'h20) ? shreg[31:8] : shreg[23:0];
        if (cnt == 6'h20 && crc_of(shreg[31:8]) !== shreg[7:0]) err = 1'b1;
        else if (cnt == 6'h18 || cnt == 6'h20) begin
            commits = commits + 8'h01;
            if (word[23:22] == MODE_SPECIAL) begin
                if (word[21:16] == SF_CONTROL) bank = word[2];
                if (word[21:16] == SF_READBACK) begin
                    rd_pend = 1'b1;
                    rb_shift = (word[15:0] == CTRL_SEL) ? {20'h0, err, bank, 2'h0}
                                                        : {8'h00, ~word[15:0]};
                    if (word[15:0] == CTRL_SEL) err = 1'b0;
                end
            end else if (word[23:22] == MODE_DATA) bank_used = bank;
        end
    end
    // released line shows a toggling pattern, not the last bit
    always @(posedge clk) fill <= ~fill;
    assign sdo = rd_pend ? rb_shift[23] : fill;
    assign crc_error_n = ~err;
endmodule : dac_device_model
`default_nettype wire

// ===== dv/tb_top.sv
`timescale 1ns/100ps
`default_nettype none
module tb_top;
    import dac_host_pkg::*;
    logic clk, rst_n, wr, rd, sclk, sync_n, sdi, sdo, crc_error_n, busy, bank_used, corrupt;
    logic [3:0]  addr;
    logic [31:0] wdata, rdata, rx_word, rv;
    logic [5:0]  rx_bits;
    logic [7:0]  commits;
    logic [5:0]  at [5] = '{6'h00, 6'h01, 6'h02, 6'h09, 6'h13};
    logic [1:0]  md [3] = '{MODE_DATA, MODE_OFFSET, MODE_GAIN};
    int          chn [5] = '{8, 4, 4, 1, 1};
    int          num_errors, check_count, ncommit, gap, k, sel;
    integer      seed = 32'h25bb470c;
    logic [23:0] w;

    dac_serial_host dut (.clk(clk), .rst_n(rst_n), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
        .rdata(rdata), .sclk(sclk), .sync_n(sync_n), .sdi(sdi), .sdo(sdo),
        .crc_error_n(crc_error_n), .busy(busy));
    dac_device_model dev (.clk(clk), .sclk(sclk), .sync_n(sync_n), .sdi(sdi), .corrupt(corrupt),
        .sdo(sdo), .crc_error_n(crc_error_n), .rx_word(rx_word), .rx_bits(rx_bits),
        .commits(commits), .bank_used(bank_used));

    function automatic logic [7:0] crc8(input logic [23:0] v);
        logic [7:0] c;
        c = 8'h00;
        for (int i = 23; i >= 0; i--) c = {c[6:0], 1'b0} ^ ((c[7] ^ v[i]) ? CRC_POLY : 8'h00);
        return c;
    endfunction : crc8
    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        check_count++;
        if (g !== e) begin
            num_errors++;
            $display("wrong value at %0t got %h exp %h", $time, g, e);
        end
    endtask : chk
    task automatic wr_reg(input logic [3:0] a, input logic [31:0] d);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
    endtask : wr_reg
    task automatic rd_chk(input logic [3:0] a, input logic [31:0] e);
        @(posedge clk);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        #1 chk(rdata, e);
    endtask : rd_chk
    // sync fall, sync rise, then count pacing until busy drops
    task automatic wait_done();
        k = 0;
        while (sync_n !== 1'b0 && k < 100) begin @(posedge clk); k++; end
        while (sync_n !== 1'b1 && k < 2000) begin @(posedge clk); k++; end
        gap = 0;
        while (busy !== 1'b0 && gap < 1000) begin @(posedge clk); gap++; end
        if (k >= 2000 || gap >= 1000) begin
            num_errors++;
            $display("wrong value at %0t frame hung, sync %h busy %h", $time, sync_n, busy);
        end
    endtask : wait_done
    task automatic frame(input logic [23:0] v, input logic c, input logic r);
        wr_reg(REG_WORD, {8'h00, v});
        wr_reg(REG_CTRL, {29'h0, r, 1'b1, c});
        #1 chk(busy, 1'b1);
        wait_done();
        if (v[23:22] != MODE_SPECIAL || c == 1'b0) ncommit++;
    endtask : frame
    task automatic results();
        $display("checks %0d errors %0d", check_count, num_errors);
        if (num_errors == 0 && check_count > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask : results

    initial begin clk = 1'b0; forever #10 clk = ~clk; end
    initial begin repeat (40000) @(posedge clk); num_errors++; results(); end
    initial begin
        {rst_n, wr, rd, corrupt, addr, wdata, num_errors, check_count, ncommit} = '0;
        repeat (4) @(posedge clk);
        rst_n <= 1'b1;
        rd_chk(REG_STATUS, 32'h0);
        rd_chk(4'hF, 32'h0);
        // data, offset and gain modes twice each, random address shape and data
        for (int i = 0; i < 6; i++) begin
            sel = $unsigned($random(seed)) % 5;
            w = {md[i % 3], at[sel], 16'($random(seed))};
            frame(w, 1'b0, 1'b0);
            chk(rx_word[23:0], w);
            chk(rx_bits, 24);
            chk(commits, ncommit);
            chk(gap + 2 >= chn[sel] * STAGE1_CYC, 1);
        end
        frame(24'hC9_1234, 1'b1, 1'b0);
        chk(rx_word, {24'hC9_1234, crc8(24'hC9_1234)});
        chk(commits, ncommit);
        // corrupted checksum frame must be suppressed and flagged
        corrupt <= 1'b1;
        frame(24'hC9_5555, 1'b1, 1'b0);
        corrupt <= 1'b0;
        ncommit--;
        chk(commits, ncommit);
        rd_chk(REG_STATUS, 32'h2);
        // read back control register, then a no-op frame carries it out
        frame({MODE_SPECIAL, SF_READBACK, 16'h0080}, 1'b0, 1'b1);
        frame(24'hFF_FFFF, 1'b0, 1'b0);
        chk(rx_word[23:0], NOP_WORD);
        rd_chk(REG_RDATA, 32'h0000_0008);
        rd_chk(REG_STATUS, 32'h0);
        frame({MODE_SPECIAL, SF_CONTROL, 16'h0004}, 1'b0, 1'b0);
        frame({MODE_DATA, 6'h0A, 16'hBEEF}, 1'b0, 1'b0);
        chk(bank_used, 1);
        // word register refuses writes while busy
        wr_reg(REG_WORD, 32'h00_F0A5C3);
        wr_reg(REG_CTRL, 32'h2);
        wr_reg(REG_WORD, 32'h00_0F0F0F);
        wait_done();
        ncommit++;
        rd_chk(REG_WORD, 32'h00_F0A5C3);
        chk(rx_word[23:0], 24'hF0A5C3);
        // reset in mid-frame leaves a short frame that must not commit
        wr_reg(REG_CTRL, 32'h2);
        repeat (100) @(posedge clk);
        rst_n <= 1'b0;
        repeat (4) @(posedge clk);
        rst_n <= 1'b1;
        @(posedge clk);
        chk(commits, ncommit);
        chk(sync_n, 1);
        rd_chk(REG_STATUS, 32'h0);
        results();
    end
endmodule : tb_top
`default_nettype wire
